// File: verilog/eec_pkg.sv
package eec_pkg;

  // line counts and pin selection
  localparam int EEC_NUM_LINES = 19;
  localparam int EEC_NUM_EXT = 16;
  localparam int EEC_NUM_PINS = 112;
  localparam int EEC_SEL_W = 7;
  localparam int EEC_SEL_FIELD = 8;
  localparam int EEC_SEL_PER_WORD = 4;
  localparam int EEC_SEL_WORDS = 4;

  // bus widths
  localparam int EEC_AW = 12;
  localparam int EEC_DW = 32;

  // register byte offsets
  localparam logic [11:0] EEC_OFS_IRQ_EN = 12'h000;
  localparam logic [11:0] EEC_OFS_EVT_EN = 12'h004;
  localparam logic [11:0] EEC_OFS_RISE = 12'h008;
  localparam logic [11:0] EEC_OFS_FALL = 12'h00C;
  localparam logic [11:0] EEC_OFS_PEND = 12'h010;
  localparam logic [11:0] EEC_OFS_PEND_CLR = 12'h014;
  localparam logic [11:0] EEC_OFS_SEL0 = 12'h018;
  localparam logic [11:0] EEC_OFS_STEP = 12'h004;

  // reset values
  localparam logic [18:0] EEC_RST_MASK = 19'h00000;
  localparam logic [6:0] EEC_RST_SEL = 7'h00;
  localparam logic [31:0] EEC_RST_RDATA = 32'h00000000;

  // apb request carried as one bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } eec_apb_req_s;

endpackage : eec_pkg

// File: verilog/eec_edge_catch.sv
`timescale 1ns/1ps
module eec_edge_catch
  import eec_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line and trigger selection
  input wire logic line_in,
  input wire logic rise_en,
  input wire logic fall_en,
  // detected edge, one pclk cycle
  output logic edge_pulse
);

  logic rise_tog_r;
  logic fall_tog_r;
  logic rise_s1_r;
  logic rise_s2_r;
  logic rise_s3_r;
  logic fall_s1_r;
  logic fall_s2_r;
  logic fall_s3_r;
  logic edge_pulse_r;
  wire rise_seen;
  wire fall_seen;

  // edges toggle flops clocked by the line itself, so narrow pulses stay caught
  always_ff @(posedge line_in or negedge presetn)
  begin
    if (!presetn)
      rise_tog_r <= 1'b0;
    else
      rise_tog_r <= ~rise_tog_r;
  end

  always_ff @(negedge line_in or negedge presetn)
  begin
    if (!presetn)
      fall_tog_r <= 1'b0;
    else
      fall_tog_r <= ~fall_tog_r;
  end

  // toggles cross into pclk through two flops, third one for change detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rise_s1_r <= 1'b0;
      rise_s2_r <= 1'b0;
      rise_s3_r <= 1'b0;
      fall_s1_r <= 1'b0;
      fall_s2_r <= 1'b0;
      fall_s3_r <= 1'b0;
      edge_pulse_r <= 1'b0;
    end
    else
    begin
      rise_s1_r <= rise_tog_r;
      rise_s2_r <= rise_s1_r;
      rise_s3_r <= rise_s2_r;
      fall_s1_r <= fall_tog_r;
      fall_s2_r <= fall_s1_r;
      fall_s3_r <= fall_s2_r;
      edge_pulse_r <= (rise_seen & rise_en) | (fall_seen & fall_en);
    end
  end

  assign rise_seen = rise_s2_r ^ rise_s3_r;
  assign fall_seen = fall_s2_r ^ fall_s3_r;
  assign edge_pulse = edge_pulse_r;

endmodule : eec_edge_catch

// File: verilog/eec_top.sv
// Behaviour
// - There are 19 independent edge detector lines, each able to raise an interrupt or an event request.
// - Each line chooses rising edges, falling edges or both as its trigger.
// - Each line has its own mask, and masking one line never affects another.
// - A readable pending flag per line is set when that line's selected edge occurs.
// - Edges are caught without sampling by pclk, so pulses shorter than a pclk period are kept.
// - Each of the 16 external lines selects one of up to 112 general-purpose pins.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module eec_top
  import eec_pkg::*;
#(
  parameter int NUM_PINS = EEC_NUM_PINS
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire eec_apb_req_s apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // line sources
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire logic [2:0] int_src_in,
  // requests toward the nested_vector_irq_controller
  output logic irq,
  output logic [18:0] irq_lines,
  output logic [18:0] evt_pulse
);

  // configuration, pending and selector registers
  logic [18:0] irq_en_r;
  logic [18:0] evt_en_r;
  logic [18:0] rise_r;
  logic [18:0] fall_r;
  logic [18:0] pend_r;
  logic [18:0] pend_nxt;
  logic [6:0] sel_r [EEC_NUM_EXT];
  // registered bus answer and request outputs
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic [18:0] irq_lines_r;
  logic [18:0] evt_pulse_r;

  // selection, decode and forwarding
  wire [18:0] line_vec;
  wire [18:0] edge_vec;
  wire [31:0] sel_word [EEC_SEL_WORDS];
  wire [EEC_SEL_WORDS-1:0] hit_sel;
  wire access;
  wire wr_do;
  wire hit_irq_en;
  wire hit_evt_en;
  wire hit_rise;
  wire hit_fall;
  wire hit_pend;
  wire hit_clr;
  wire mapped;
  wire [18:0] clr_mask;
  wire [31:0] rd_val;
  wire wr_irq_en;
  wire wr_evt_en;
  wire wr_rise;
  wire wr_fall;
  wire wr_clr;
  wire [EEC_SEL_WORDS-1:0] wr_sel;
  wire [18:0] irq_fwd;
  wire [18:0] evt_fwd;

  // external lines come from the pin selector, internal ones from fixed sources
  genvar gi;
  generate
    for (gi = 0; gi < EEC_NUM_EXT; gi++)
    begin : g_pinsel
      assign line_vec[gi] = (32'(sel_r[gi]) < NUM_PINS) ? gpio_in[sel_r[gi]] : 1'b0;
    end
    for (gi = 0; gi < EEC_SEL_WORDS; gi++)
    begin : g_selword
      assign hit_sel[gi] = apb_req.paddr == EEC_AW'(EEC_OFS_SEL0 + EEC_OFS_STEP * gi);
      assign wr_sel[gi] = wr_do & hit_sel[gi];
      assign sel_word[gi] = {1'b0, sel_r[4*gi+3], 1'b0, sel_r[4*gi+2],
                             1'b0, sel_r[4*gi+1], 1'b0, sel_r[4*gi]};
    end
    for (gi = 0; gi < EEC_NUM_LINES; gi++)
    begin : g_line
      // one detector per line
      eec_edge_catch i_eec_edge_catch (
        .pclk(pclk),
        .presetn(presetn),
        .line_in(line_vec[gi]),
        .rise_en(rise_r[gi]),
        .fall_en(fall_r[gi]),
        .edge_pulse(edge_vec[gi])
      );
    end
  endgenerate

  assign line_vec[18:16] = int_src_in;

  // apb decode
  assign access = apb_req.psel & apb_req.penable;
  assign wr_do = access & pready_r & apb_req.pwrite;
  assign hit_irq_en = apb_req.paddr == EEC_OFS_IRQ_EN;
  assign hit_evt_en = apb_req.paddr == EEC_OFS_EVT_EN;
  assign hit_rise = apb_req.paddr == EEC_OFS_RISE;
  assign hit_fall = apb_req.paddr == EEC_OFS_FALL;
  assign hit_pend = apb_req.paddr == EEC_OFS_PEND;
  assign hit_clr = apb_req.paddr == EEC_OFS_PEND_CLR;
  assign mapped = hit_irq_en | hit_evt_en | hit_rise | hit_fall | hit_pend | hit_clr | (|hit_sel);

  // per-register write strobes
  assign wr_irq_en = wr_do & hit_irq_en;
  assign wr_evt_en = wr_do & hit_evt_en;
  assign wr_rise = wr_do & hit_rise;
  assign wr_fall = wr_do & hit_fall;
  assign wr_clr = wr_do & hit_clr;

  assign rd_val = hit_irq_en ? 32'(irq_en_r) :
                  hit_evt_en ? 32'(evt_en_r) :
                  hit_rise ? 32'(rise_r) :
                  hit_fall ? 32'(fall_r) :
                  hit_pend ? 32'(pend_r) :
                  hit_sel[0] ? sel_word[0] :
                  hit_sel[1] ? sel_word[1] :
                  hit_sel[2] ? sel_word[2] :
                  hit_sel[3] ? sel_word[3] : 32'h00000000;

  // clear by writing ones; a new edge in the same cycle keeps the flag
  assign clr_mask = wr_clr ? apb_req.pwdata[18:0] : 19'h00000;
  assign pend_nxt = (pend_r & ~clr_mask) | edge_vec;

  // requests forwarded past the masks
  assign irq_fwd = pend_nxt & irq_en_r;
  assign evt_fwd = edge_vec & evt_en_r;

  // bus slave: one wait cycle, then the answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= EEC_RST_RDATA;
    end
    else
    begin
      pready_r <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~mapped;
      if (access & ~pready_r & ~apb_req.pwrite)
        prdata_r <= rd_val;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_en_r <= EEC_RST_MASK;
      evt_en_r <= EEC_RST_MASK;
      rise_r <= EEC_RST_MASK;
      fall_r <= EEC_RST_MASK;
    end
    else
    begin
      if (wr_irq_en)
        irq_en_r <= apb_req.pwdata[18:0];
      if (wr_evt_en)
        evt_en_r <= apb_req.pwdata[18:0];
      if (wr_rise)
        rise_r <= apb_req.pwdata[18:0];
      if (wr_fall)
        fall_r <= apb_req.pwdata[18:0];
    end
  end

  // pin selectors, four to a word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < EEC_NUM_EXT; i++)
        sel_r[i] <= EEC_RST_SEL;
    end
    else
    begin
      for (int i = 0; i < EEC_NUM_EXT; i++)
        if (wr_sel[i/EEC_SEL_PER_WORD])
          sel_r[i] <= apb_req.pwdata[EEC_SEL_FIELD*(i%EEC_SEL_PER_WORD) +: EEC_SEL_W];
    end
  end

  // pending flags and request outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_r <= EEC_RST_MASK;
      irq_lines_r <= EEC_RST_MASK;
      evt_pulse_r <= EEC_RST_MASK;
      irq_r <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      irq_lines_r <= irq_fwd;
      irq_r <= |irq_fwd;
      evt_pulse_r <= evt_fwd;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign irq = irq_r;
  assign irq_lines = irq_lines_r;
  assign evt_pulse = evt_pulse_r;

endmodule : eec_top

// File: sim/eec_top_monitor.sv
`timescale 1ns/1ps
module eec_top_monitor
  import eec_pkg::*;
#(
  parameter int NUM_PINS = EEC_NUM_PINS
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire eec_apb_req_s apb_req,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // lines
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire logic [2:0] int_src_in,
  input wire logic irq,
  input wire logic [18:0] irq_lines,
  input wire logic [18:0] evt_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = apb_req.psel && apb_req.penable;
  wire logic clr_wr = acc && pready && apb_req.pwrite &&
    (apb_req.paddr == EEC_OFS_PEND_CLR || apb_req.paddr == EEC_OFS_IRQ_EN);
  a_irq_any: assert property (irq == (|irq_lines))
    else $error("irq differs from line summary");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && irq_lines == '0 && evt_pulse == '0)
    else $error("outputs active after reset");
  a_ready_wait: assert property ($rose(acc) |-> !pready ##1 pready)
    else $error("access not one wait state");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_addr: assert property (acc && pready |->
    pslverr == (apb_req.paddr > 12'h024 || apb_req.paddr[1:0] != 2'b00))
    else $error("error flag wrong for address");
  a_pend_hold: assert property (|($past(irq_lines) & ~irq_lines) |-> $past(clr_wr) || $past(clr_wr, 2))
    else $error("line request dropped unprompted");
  a_rdata_hold: assert property (!$stable(prdata) |-> pready && !apb_req.pwrite)
    else $error("read data moved outside a read");
endmodule : eec_top_monitor

bind eec_top eec_top_monitor #(.NUM_PINS(NUM_PINS)) i_eec_top_monitor (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .pready(pready), .pslverr(pslverr), .prdata(prdata), .gpio_in(gpio_in),
  .int_src_in(int_src_in), .irq(irq), .irq_lines(irq_lines), .evt_pulse(evt_pulse));

// File: sim/eec_pin_model.sv
`timescale 1ns/1ps
module eec_pin_model
  import eec_pkg::*;
(
  // pin levels
  output logic [EEC_NUM_PINS-1:0] gpio,
  output logic [2:0] isrc
);
  initial
  begin
    gpio = '0;
    isrc = '0;
  end
  // called right after a rising edge, so levels move off the sampling point
  task set(input int i, input logic v);
    if (i < EEC_NUM_PINS)
      gpio[i] <= v;
    else
      isrc[i-EEC_NUM_PINS] <= v;
  endtask : set
  // high for 2 ns, well under one pclk period
  task pulse(input int i);
    set(i, 1'b1);
    #2;
    set(i, 1'b0);
  endtask : pulse
endmodule : eec_pin_model

// File: sim/eec_top_bench.sv
`timescale 1ns/1ps
module eec_top_bench
  import eec_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  eec_apb_req_s req = '0;
  logic pready, pslverr, irq;
  logic [31:0] prdata;
  logic [18:0] irq_lines, evt_pulse;
  wire logic [EEC_NUM_PINS-1:0] gpio;
  wire logic [2:0] isrc;
  logic [33:0] q[$];
  logic [33:0] e;
  int failures = 0;
  int num_checks = 0;
  int seed = 6;
  int evt_cnt = 0;
  int ln, pin;
  always #5 pclk = ~pclk;
  eec_top i_eec_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .gpio_in(gpio), .int_src_in(isrc), .irq(irq), .irq_lines(irq_lines),
    .evt_pulse(evt_pulse));
  eec_pin_model i_eec_pin_model (.gpio(gpio), .isrc(isrc));
  task chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, s, x);
    end
  endtask : chk
  task end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] x);
    int n;
    q.push_back(x);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    req <= '0;
    if (n >= 20)
    begin
      failures++;
      end_of_test();
    end
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'b01, x});
  endtask : rd
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask : wr
  task edge_chk(input int p, input int l, input logic v, input logic x);
    i_eec_pin_model.set(p, v);
    repeat (8) @(posedge pclk);
    rd(EEC_OFS_PEND, 32'(x) << l);
    chk(32'(irq_lines), 32'(x) << l);
    chk(32'(irq), 32'(x));
    wr(EEC_OFS_PEND_CLR, 32'h1 << l);
  endtask : edge_chk
  always @(posedge pclk)
  begin
    evt_cnt <= evt_cnt + $countones(evt_pulse);
    if (pready === 1'b1)
    begin
      if (q.size() == 0)
        chk(32'h0, 32'h1);
      else
      begin
        e = q.pop_front();
        chk(32'(pslverr), 32'(e[33]));
        if (e[32])
          chk(prdata, e[31:0]);
      end
    end
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 'h24; a += 4)
      rd(12'(a), 32'h0);
    apb(1'b0, 12'h100, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 12'h100, 32'hFFFFFFFF, {2'b10, 32'h0});
    wr(EEC_OFS_EVT_EN, 32'hFFFFFFFF);
    rd(EEC_OFS_EVT_EN, 32'h0007FFFF);
    for (int m = 1; m < 4; m++)
    begin
      ln = $unsigned($random(seed)) % EEC_NUM_EXT;
      pin = $unsigned($random(seed)) % EEC_NUM_PINS;
      wr(EEC_OFS_RISE, 32'h0);
      wr(EEC_OFS_FALL, 32'h0);
      wr(EEC_OFS_SEL0 + 12'(4 * (ln / 4)), pin << (8 * (ln % 4)));
      rd(EEC_OFS_SEL0 + 12'(4 * (ln / 4)), pin << (8 * (ln % 4)));
      wr(EEC_OFS_IRQ_EN, 32'h1 << ln);
      wr(EEC_OFS_RISE, (m & 1) << ln);
      wr(EEC_OFS_FALL, (m >> 1) << ln);
      edge_chk(pin, ln, 1'b1, 1'(m & 1));
      edge_chk(pin, ln, 1'b0, 1'(m >> 1));
    end
    wr(EEC_OFS_FALL, 32'h0);
    i_eec_pin_model.pulse(pin);
    repeat (8) @(posedge pclk);
    wr(EEC_OFS_PEND_CLR, 32'h0);
    rd(EEC_OFS_PEND, 32'h1 << ln);
    wr(EEC_OFS_IRQ_EN, 32'h0);
    wr(EEC_OFS_RISE, 32'h7 << 16);
    for (int k = 0; k < 3; k++)
      i_eec_pin_model.set(EEC_NUM_PINS + k, 1'b1);
    repeat (8) @(posedge pclk);
    rd(EEC_OFS_PEND, (32'h7 << 16) | (32'h1 << ln));
    chk(32'(irq), 32'h0);
    wr(EEC_OFS_PEND, 32'h0);
    rd(EEC_OFS_PEND, (32'h7 << 16) | (32'h1 << ln));
    wr(EEC_OFS_IRQ_EN, 32'h1 << 16);
    repeat (2) @(posedge pclk);
    chk(32'(irq_lines), 32'h1 << 16);
    chk(32'(irq), 32'h1);
    chk(32'(evt_cnt), 32'd8);
    end_of_test();
  end
endmodule : eec_top_bench
